// >>> core/scs_subcode_out.sv
/*
 * Subcode P to W serial output with frame and block sync and the
 * block sync interrupt toward the on-chip controller.
 * Assumes the disc decoder supplies subcode symbols, frame and block
 * sync pulses in the mclk_i domain; the read clock pin may come from
 * outside and is sampled through two flip-flops.
 */
//
// Overview of operation
// (R1) The subcode read clock pin is the clock, in or out, for P-W bits.
// (R2) The read clock polarity is inverted in both senses on command.
// (R3) Subcode P-W bits leave serially on the data pin with that clock.
// (R4) A frame sync output marks each playback frame.
// (R5) Block sync output goes high when a subcode sync is detected.
// (R6) The controller must enable the disc interrupt to get them.
// (R7) When enabled, a block sync falling edge raises vector 2 request.
// (R8) The controller should keep it disabled while state is undefined.
// (R9) Each shared pin switches alone between port and disc function.
// (R10) The request stays pending until the controller accepts it; the code also drops it when the interrupt is disabled.
`timescale 1ns/1ps
module scs_subcode_out (
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  // Decoder side
  input  wire logic [7:0]                    sub_symbol_i,
  input  wire logic                          sub_valid_i,
  input  wire logic                          frame_sync_i,
  input  wire logic                          block_det_i,
  // Controller side
  input  wire logic                          clk_invert_i,
  input  wire logic                          clk_out_mode_i,
  input  wire logic                          int_enable_i,
  input  wire logic                          int_ack_i,
  input  wire logic [scs_pkg::NUM_PINS-1:0]  pin_sel_i,
  input  wire logic [scs_pkg::NUM_PINS-1:0]  port_out_i,
  input  wire logic [scs_pkg::NUM_PINS-1:0]  port_oe_i,
  output logic                               int_req_o,
  output logic [3:0]                         int_vector_o,
  // Shared pins
  input  wire logic                          subcode_read_clock_i,
  output logic [scs_pkg::NUM_PINS-1:0]       pin_o,
  output logic [scs_pkg::NUM_PINS-1:0]       pin_oe_o
);

  ////////////////////////////////////////////////////////////////////
  // Read clock sampling and edge finding

  logic clk_sync;
  logic clk_prev_q;
  logic clk_norm;
  logic clk_rise;

  scs_sync2 u_clk_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .async_i (subcode_read_clock_i),
    .sync_o  (clk_sync)
  );

  // Remove the selected polarity before edge detection.
  // Change polarity only while idle: the sampled pin lags the select
  // by two cycles, so a switch in mid-symbol would show a false edge.
  assign clk_norm = clk_sync ^ clk_invert_i; // see (R2)

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_norm;
    end
  end

  // Active edge of the read clock in its normalised sense
  assign clk_rise = clk_norm & ~clk_prev_q; // see (R1)

  ////////////////////////////////////////////////////////////////////
  // Internally generated read clock for output mode

  scs_pkg::scs_state_t                state_q;
  logic gen_clk_q;
  logic gen_fall;
  logic shift_tick;

  // Toggle each cycle only while shifting, so the clock parks low
  // after the last bit and no stray edge follows the symbol
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gen_clk_q <= 1'b0;
    end else if (state_q == scs_pkg::SCS_SHIFT) begin
      gen_clk_q <= ~gen_clk_q;
    end else begin
      gen_clk_q <= 1'b0;
    end
  end

  // Shift as the generated clock falls, so the data bit stands
  // steady around the rising edge that the reader uses
  assign gen_fall   = gen_clk_q;
  assign shift_tick = clk_out_mode_i ? gen_fall : clk_rise; // see (R1)

  ////////////////////////////////////////////////////////////////////
  // Subcode shifter

  logic [7:0]                         shift_q;
  logic [scs_pkg::SUB_CNT_W-1:0]      bit_cnt_q;
  logic [7:0]                         pend_q;
  logic                               pend_vld_q;

  // One symbol waiting while the previous one shifts out
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q     <= scs_pkg::SUB_RESET;
      pend_vld_q <= 1'b0;
    end else if (sub_valid_i) begin
      pend_q     <= sub_symbol_i;
      pend_vld_q <= 1'b1;
    end else if (state_q == scs_pkg::SCS_IDLE && pend_vld_q) begin
      pend_vld_q <= 1'b0;
    end
  end

  // Shift P first; one bit per active read clock edge
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q   <= scs_pkg::SCS_IDLE;
      shift_q   <= scs_pkg::SUB_RESET;
      bit_cnt_q <= '0;
    end else begin
      case (state_q)
        scs_pkg::SCS_IDLE: begin
          if (pend_vld_q && !sub_valid_i) begin
            shift_q   <= pend_q;
            bit_cnt_q <= '0;
            state_q   <= scs_pkg::SCS_SHIFT;
          end
        end
        scs_pkg::SCS_SHIFT: begin
          if (shift_tick) begin // see (R3)
            if (bit_cnt_q == scs_pkg::SUB_LAST) begin
              state_q <= scs_pkg::SCS_HOLD;
            end else begin
              shift_q   <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 3'h1;
            end
          end
        end
        scs_pkg::SCS_HOLD: begin
          state_q <= scs_pkg::SCS_IDLE;
        end
        default: begin
          state_q <= scs_pkg::SCS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sync outputs and block sync interrupt

  logic fsync_q;
  logic bsync_q;
  logic bsync_fall;

  // Frame and block sync levels
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      fsync_q <= 1'b0;
      bsync_q <= 1'b0;
    end else begin
      fsync_q <= frame_sync_i; // see (R4)
      bsync_q <= block_det_i;  // see (R5)
    end
  end

  assign bsync_fall = bsync_q & ~block_det_i;

  // Pending request; a new edge wins over the acknowledge
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      int_req_o <= 1'b0;
    end else if (bsync_fall && int_enable_i) begin // see (R7) (R6)
      int_req_o <= 1'b1;
    end else if (int_ack_i || !int_enable_i) begin
      int_req_o <= 1'b0; // see (R10) (R8)
    end
  end

  // Vector presented with the request
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      int_vector_o <= 4'h0;
    end else begin
      int_vector_o <= scs_pkg::BSYNC_VECTOR; // see (R7)
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shared pin multiplexer

  logic [scs_pkg::NUM_PINS-1:0] fn_val;
  logic [scs_pkg::NUM_PINS-1:0] fn_oe;

  // Disc function values; read clock re-inverted on output
  always_comb begin
    fn_val = '0;
    fn_oe  = '1;
    fn_val[scs_pkg::PIN_CLK]   = gen_clk_q ^ clk_invert_i; // see (R2)
    fn_oe[scs_pkg::PIN_CLK]    = clk_out_mode_i;
    fn_val[scs_pkg::PIN_DATA]  = (state_q == scs_pkg::SCS_SHIFT) &
                                 shift_q[7];
    fn_val[scs_pkg::PIN_FSYNC] = fsync_q;
    fn_val[scs_pkg::PIN_BSYNC] = bsync_q;
  end

  // Per pin choice between port and disc function
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_o    <= scs_pkg::SEL_RESET;
      pin_oe_o <= scs_pkg::SEL_RESET;
    end else begin
      for (int i = 0; i < scs_pkg::NUM_PINS; i++) begin
        pin_o[i]    <= pin_sel_i[i] ? fn_val[i] : port_out_i[i]; // see (R9)
        pin_oe_o[i] <= pin_sel_i[i] ? fn_oe[i]  : port_oe_i[i];
      end
    end
  end

endmodule : scs_subcode_out

// >>> core/scs_pkg.sv
/*
 * Package for the subcode output and block sync interrupt block.
 * Holds pin function selects, field positions, reset values and
 * the interrupt vector used by the controller.
 * Assumes a single processor clock domain at 50 MHz.
 */
package scs_pkg;

  // Number of shared pins that can be switched to the disc function
  localparam int unsigned NUM_PINS        = 4;
  // Pin indices within the shared pin group
  localparam int unsigned PIN_CLK         = 0;
  localparam int unsigned PIN_DATA        = 1;
  localparam int unsigned PIN_FSYNC       = 2;
  localparam int unsigned PIN_BSYNC       = 3;
  // Subcode symbol width (P through W)
  localparam int unsigned SUB_BITS        = 8;
  localparam int unsigned SUB_CNT_W       = 3;
  localparam logic [SUB_CNT_W-1:0] SUB_LAST = 3'h7;
  // Interrupt vector address for the block sync interrupt
  localparam logic [3:0]  BSYNC_VECTOR    = 4'h2;
  // Reset values
  localparam logic [7:0]  SUB_RESET       = 8'h00;
  localparam logic [NUM_PINS-1:0] SEL_RESET = 4'h0;

  // Subcode clock state machine, Gray coded from IDLE through SHIFT to HOLD
  typedef enum logic [1:0] {
    SCS_IDLE  = 2'b00,
    SCS_SHIFT = 2'b01,
    SCS_HOLD  = 2'b11
  } scs_state_t;

endpackage : scs_pkg

// >>> core/scs_sync2.sv
/*
 * Two flip-flop synchroniser for one level from outside the clock.
 * Assumes the input may change at any time relative to mclk_i.
 */
`timescale 1ns/1ps
module scs_sync2 (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : scs_sync2

// >>> tb/scs_subcode_monitor.sv
/* Checker for the subcode output block, bound to its ports.
   Assumes the bench holds all inputs low during reset. */
`timescale 1ns/1ps
module scs_subcode_monitor (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       frame_sync_i,
  input wire logic       block_det_i,
  input wire logic       int_enable_i,
  input wire logic       int_ack_i,
  input wire logic [3:0] pin_sel_i,
  input wire logic [3:0] port_out_i,
  input wire logic       int_req_o,
  input wire logic [3:0] int_vector_o,
  input wire logic [3:0] pin_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////
  // Interrupt request and vector
  a_vec_fixed:
    assert property (!$past(reset_i) |->
                     int_vector_o == scs_pkg::BSYNC_VECTOR)
    else $error("vector wrong");
  a_int_set:
    assert property ($fell(block_det_i) && int_enable_i |=> int_req_o)
    else $error("no request");
  a_int_clear:
    assert property (int_ack_i && !$fell(block_det_i) |=> !int_req_o)
    else $error("ack ignored");
  a_int_hold:
    assert property (int_req_o && int_enable_i && !int_ack_i |=> int_req_o)
    else $error("request lost");
  a_int_drop:
    assert property (!int_enable_i |=> !int_req_o)
    else $error("request while off");
  ////////////////////////////////////////////////////////////////////////
  // Sync outputs and port function
  a_fsync_dly:
    assert property ($past(pin_sel_i[2]) |->
                     pin_o[2] == $past(frame_sync_i, 2))
    else $error("frame sync wrong");
  a_bsync_dly:
    assert property ($past(pin_sel_i[3]) |->
                     pin_o[3] == $past(block_det_i, 2))
    else $error("block sync wrong");
  a_port_data:
    assert property (!$past(pin_sel_i[1]) |->
                     pin_o[1] == $past(port_out_i[1]))
    else $error("port value wrong");
endmodule : scs_subcode_monitor

bind scs_subcode_out scs_subcode_monitor u_scs_subcode_monitor (
  .mclk_i       (mclk_i),
  .reset_i      (reset_i),
  .frame_sync_i (frame_sync_i),
  .block_det_i  (block_det_i),
  .int_enable_i (int_enable_i),
  .int_ack_i    (int_ack_i),
  .pin_sel_i    (pin_sel_i),
  .port_out_i   (port_out_i),
  .int_req_o    (int_req_o),
  .int_vector_o (int_vector_o),
  .pin_o        (pin_o)
);

// >>> tb/scs_ctl_model.sv
/* Controller model: reads subcode bits with its own read clock and
   accepts block sync interrupts. Assumes the bench starts each read. */
`timescale 1ns/1ps
module scs_ctl_model (
  input  wire logic mclk_i,
  input  wire logic inv_i,
  input  wire logic data_i,
  input  wire logic req_i,
  output logic      rclk_o,
  output logic      ack_o
);
  logic clk_q = 1'b0;
  logic ack_q = 1'b0;
  // Read clock stands still between symbols, polarity per command
  assign rclk_o = clk_q ^ inv_i;
  // Accept a pending request after a random wait
  assign ack_o = ack_q;
  always @(posedge mclk_i) ack_q <= req_i && !ack_q && ($urandom % 4 == 0);
  // Shift in one symbol, P first, one bit per 160 ns read clock period;
  // the clock moves on falling block clock edges, off the sampling edge
  task automatic read_sym(output logic [7:0] s);
    s = 8'h00;
    repeat (8) begin
      s = {s[6:0], data_i};
      repeat (4) @(negedge mclk_i);
      clk_q = 1'b1;
      repeat (4) @(negedge mclk_i);
      clk_q = 1'b0;
    end
  endtask : read_sym
endmodule : scs_ctl_model

// >>> tb/scs_subcode_out_tb.sv
/* Testbench for the subcode output block with a controller model.
   Assumes a 50 MHz block clock and a 160 ns read clock. */
`timescale 1ns/1ps
module scs_subcode_out_tb;
  logic       mclk_i = 1'b0, reset_i = 1'b1, rclk;
  logic [7:0] sub_symbol_i, s, v;
  logic       sub_valid_i, frame_sync_i, block_det_i, clk_invert_i;
  logic       clk_out_mode_i, int_enable_i, int_ack_i, int_req_o;
  logic [3:0] pin_sel_i, port_out_i, port_oe_i, int_vector_o;
  logic [3:0] pin_o, pin_oe_o;
  logic [7:0] q[$];
  int         fails = 0, compares = 0;
  int         n, c;
  logic       cur, prev;
  scs_subcode_out u_scs_subcode_out (
    .mclk_i               (mclk_i),
    .reset_i              (reset_i),
    .sub_symbol_i         (sub_symbol_i),
    .sub_valid_i          (sub_valid_i),
    .frame_sync_i         (frame_sync_i),
    .block_det_i          (block_det_i),
    .clk_invert_i         (clk_invert_i),
    .clk_out_mode_i       (clk_out_mode_i),
    .int_enable_i         (int_enable_i),
    .int_ack_i            (int_ack_i),
    .pin_sel_i            (pin_sel_i),
    .port_out_i           (port_out_i),
    .port_oe_i            (port_oe_i),
    .int_req_o            (int_req_o),
    .int_vector_o         (int_vector_o),
    .subcode_read_clock_i (rclk),
    .pin_o                (pin_o),
    .pin_oe_o             (pin_oe_o)
  );
  scs_ctl_model u_scs_ctl_model (.mclk_i(mclk_i), .inv_i(clk_invert_i),
    .data_i(pin_o[1]), .req_i(int_req_o), .rclk_o(rclk), .ack_o(int_ack_i));
  ////////////////////////////////////////////////////////////////////////
  // Compare and closing tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Clock and watchdog
  initial forever #10 mclk_i = ~mclk_i;
  initial begin
    #300us fails++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(89626));
    {sub_symbol_i, sub_valid_i, frame_sync_i, block_det_i} = '0;
    {clk_invert_i, clk_out_mode_i, int_enable_i} = '0;
    {pin_sel_i, port_out_i, port_oe_i} = '0;
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 check(int_vector_o, 8'h02);
    // Port function on every pin
    repeat (8) begin
      @(posedge mclk_i);
      port_out_i <= 4'($urandom);
      port_oe_i <= 4'($urandom);
      @(posedge mclk_i) #1;
      check({pin_oe_o, pin_o}, {port_oe_i, port_out_i});
    end
    @(posedge mclk_i);
    pin_sel_i <= 4'hF;
    // Symbols in both polarities; later ones wait in the one slot,
    // where the newest overwrites an older waiting symbol
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      clk_invert_i <= 1'(i / 4);
      repeat (8) @(posedge mclk_i);
      n = (i % 2 == 0) ? 1 : 2 + i / 7;
      for (int k = 0; k < n; k++) begin
        v = 8'($urandom);
        if (k == 0 || k == n - 1) q.push_back(v);
        sub_symbol_i <= v;
        sub_valid_i <= 1'b1;
        frame_sync_i <= 1'($urandom);
        @(posedge mclk_i);
        sub_valid_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
      end
      repeat (q.size()) begin
        repeat (10) @(negedge mclk_i);
        u_scs_ctl_model.read_sym(s);
        check(s, q.pop_front());
      end
      check(8'(pin_oe_o[0]), 8'h00);
    end
    // Block drives the read clock; take a bit at each active edge
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      clk_out_mode_i <= 1'b1;
      clk_invert_i <= 1'(i);
      v = 8'($urandom);
      sub_symbol_i <= v;
      sub_valid_i <= 1'b1;
      @(posedge mclk_i);
      sub_valid_i <= 1'b0;
      s = 8'h00;
      c = 0;
      prev = 1'b0;
      for (int k = 0; k < 30; k++) begin
        @(posedge mclk_i) #1;
        cur = pin_o[0] ^ clk_invert_i;
        if (cur && !prev) begin
          s = {s[6:0], pin_o[1]};
          c++;
        end
        prev = cur;
      end
      check(s, v);
      check(8'(c), 8'h08);
      check(8'(pin_oe_o[0]), 8'h01);
    end
    // Block sync falls with interrupt disabled and enabled
    for (int e = 0; e < 4; e++) begin
      @(posedge mclk_i);
      int_enable_i <= e[0];
      block_det_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      block_det_i <= 1'b0;
      @(posedge mclk_i) #1;
      check(int_req_o, 8'(e[0]));
      for (int k = 0; k < 80 && int_req_o; k++) begin
        @(posedge mclk_i) #1;
      end
      check(int_req_o, 8'h00);
    end
    end_of_test();
  end
endmodule : scs_subcode_out_tb
